// ---- spf_top.v ----
// serial port, shared pin functions and conversion timing
//
// Operation
// - only bits clocked while chip select is low form a frame
// - input bits are captured on falling serial clock edges
// - read data is shifted out on rising serial clock edges
// - serial output is undriven except while shifting read data
// - busy pin is high from conversion start until it finishes
// - busy lasts at most 950 ns, or 5.85 us with temp sensor
// - load pin going high moves pending values into dac registers
// - each disable input turns off its selected dac outputs
// - alert pin active when result is above high or below low limit
// - a polarity bit sets the active level of both alert pins
// - twelve gpio pins, six with alternate functions when enabled
// - one of eight analog channels is muxed into the sampler
`include "spf_regs.vh"

module spf_top #(
   parameter NGPIO = 12,
   parameter NDAC = 4,
   parameter DW = 10
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // serial port pins
   input wire cs_n,
   input wire sclk,
   input wire din,
   output reg dout,
   output reg dout_oe,
   // gpio pins
   input wire [NGPIO-1:0] gpio_in,
   output reg [NGPIO-1:0] gpio_out,
   output reg [NGPIO-1:0] gpio_oe,
   // analog front end
   output reg [2:0] analog_mux_sel,
   output reg adc_sample,
   output reg temp_sensor_en,
   input wire [DW-1:0] adc_data,
   // dac side
   output reg [NDAC*DW-1:0] dac_codes,
   output reg [NDAC-1:0] dac_out_en,
   // interrupt
   output reg irq
);

   // ----------------------------------------
   // constants and state
   // ----------------------------------------
   localparam integer CONV_CYC_N = `SPF_CONV_CYC;
   localparam integer TEMP_CYC_N = `SPF_CONV_TEMP_CYC;
   localparam [10:0] CONV_CYC = CONV_CYC_N[10:0];
   localparam [10:0] TEMP_CYC = TEMP_CYC_N[10:0];
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   reg [7:0] ctrl;
   reg [NGPIO-1:0] gp_out;
   reg [NGPIO-1:0] gp_oe;
   reg [NDAC-1:0] off0_sel;
   reg [NDAC-1:0] off1_sel;
   reg [DW-1:0] lim_hi;
   reg [DW-1:0] lim_lo;
   reg [2:0] chan;
   reg [DW-1:0] result;
   reg range_flag;
   reg [DW-1:0] pend [0:NDAC-1];
   reg [3:0] stat;
   reg [3:0] mask;
   reg state;
   reg busy;
   reg [10:0] cnt;
   reg ev_done;
   reg ev_range;
   reg ev_load;
   reg ev_frame;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   wire [NGPIO+2:0] sync_q;
   wire [NGPIO-1:0] s_gpio;
   wire s_cs_n;
   wire s_sclk;
   wire s_din;

   // chip select and serial clock rest high: no false edge after reset
   spf_sync #(
      .W(NGPIO + 3),
      .INIT({2'b11, {(NGPIO + 1){1'b0}}})
   ) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .d({cs_n, sclk, din, gpio_in}),
      .q(sync_q)
   );

   assign s_cs_n = sync_q[NGPIO+2];
   assign s_sclk = sync_q[NGPIO+1];
   assign s_din = sync_q[NGPIO];
   assign s_gpio = sync_q[NGPIO-1:0];

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function mapped;
      input [7:0] a;
      begin
         mapped = (a <= `SPF_IRQ_MASK) && (a[1:0] == 2'b00);
      end
   endfunction

   function [31:0] rd_mux;
      input [7:0] a;
      begin
         rd_mux = 32'h00000000;
         if (a == `SPF_CTRL) begin
            rd_mux[7:0] = ctrl;
         end else if (a == `SPF_GPIO_OUT) begin
            rd_mux[NGPIO-1:0] = gp_out;
         end else if (a == `SPF_GPIO_OE) begin
            rd_mux[NGPIO-1:0] = gp_oe;
         end else if (a == `SPF_GPIO_IN) begin
            rd_mux[NGPIO-1:0] = s_gpio;
         end else if (a == `SPF_OFF0_SEL) begin
            rd_mux[NDAC-1:0] = off0_sel;
         end else if (a == `SPF_OFF1_SEL) begin
            rd_mux[NDAC-1:0] = off1_sel;
         end else if (a == `SPF_LIM_HI) begin
            rd_mux[DW-1:0] = lim_hi;
         end else if (a == `SPF_LIM_LO) begin
            rd_mux[DW-1:0] = lim_lo;
         end else if (a == `SPF_CONV) begin
            rd_mux[2:0] = chan;
            rd_mux[8] = busy;
         end else if (a == `SPF_RESULT) begin
            rd_mux[DW-1:0] = result;
            rd_mux[16] = range_flag;
         end else if (a == `SPF_IRQ_STAT) begin
            rd_mux[3:0] = stat;
         end else if (a == `SPF_IRQ_MASK) begin
            rd_mux[3:0] = mask;
         end
      end
   endfunction

   // ----------------------------------------
   // serial port
   // ----------------------------------------
   reg sclk_d;
   reg cs_d;
   reg [5:0] bcnt;
   reg [31:0] sh_in;
   reg [31:0] sh_out;
   reg reading;
   reg spi_wr;
   reg [7:0] spi_addr;
   reg [31:0] spi_wdata;
   wire sclk_fall = sclk_d & ~s_sclk;
   wire sclk_rise = ~sclk_d & s_sclk;
   wire [7:0] cmd = {sh_in[6:0], s_din};

   always @(posedge mclk) begin
      if (!reset_n) begin
         sclk_d <= 1'b1;
         cs_d <= 1'b1;
         bcnt <= 6'h00;
         sh_in <= 32'h00000000;
         sh_out <= 32'h00000000;
         reading <= 1'b0;
         spi_wr <= 1'b0;
         spi_addr <= 8'h00;
         spi_wdata <= 32'h00000000;
         dout <= 1'b0;
         dout_oe <= 1'b0;
         ev_frame <= 1'b0;
      end else begin
         sclk_d <= s_sclk;
         cs_d <= s_cs_n;
         spi_wr <= 1'b0;
         ev_frame <= s_cs_n & ~cs_d & (bcnt != 6'h00);
         if (s_cs_n) begin
            // no frame: drop partial words, release the line
            bcnt <= 6'h00;
            reading <= 1'b0;
            dout_oe <= 1'b0;
         end else begin
            if (sclk_fall) begin
               sh_in <= {sh_in[30:0], s_din};
               if (bcnt != 6'h28) begin
                  bcnt <= bcnt + 6'h01;
               end
               if (bcnt == 6'h07) begin
                  spi_addr <= {cmd[5:0], 2'b00};
                  if (cmd[7]) begin
                     sh_out <= rd_mux({cmd[5:0], 2'b00});
                     reading <= 1'b1;
                  end
               end
               if (bcnt == 6'h27 && !reading) begin
                  spi_wdata <= {sh_in[30:0], s_din};
                  spi_wr <= 1'b1;
               end
            end
            if (sclk_rise && reading) begin
               dout <= sh_out[31];
               sh_out <= {sh_out[30:0], 1'b0};
               dout_oe <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // apb slave and register writes
   // ----------------------------------------
   // apb wins a same-cycle collision; the serial write is dropped
   wire apb_wr = psel & penable & pwrite;
   wire wr_en = apb_wr | spi_wr;
   wire [7:0] wa = apb_wr ? paddr : spi_addr;
   wire [31:0] wd = apb_wr ? pwdata : spi_wdata;
   wire start = wr_en && (wa == `SPF_CONV) && !busy;
   integer i;
   integer j;

   assign pready = psel & penable;

   always @(posedge mclk) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= rd_mux(paddr);
         pslverr <= ~mapped(paddr);
      end
   end

   always @(posedge mclk) begin
      if (!reset_n) begin
         ctrl <= `SPF_CTRL_RST;
         gp_out <= {NGPIO{1'b0}};
         gp_oe <= {NGPIO{1'b0}};
         off0_sel <= {NDAC{1'b0}};
         off1_sel <= {NDAC{1'b0}};
         lim_hi <= `SPF_LIM_HI_RST;
         lim_lo <= `SPF_LIM_LO_RST;
         chan <= 3'h0;
         mask <= 4'h0;
         for (i = 0; i < NDAC; i = i + 1) begin
            pend[i] <= {DW{1'b0}};
         end
      end else if (wr_en) begin
         if (wa == `SPF_CTRL) begin
            ctrl <= wd[7:0];
         end else if (wa == `SPF_GPIO_OUT) begin
            gp_out <= wd[NGPIO-1:0];
         end else if (wa == `SPF_GPIO_OE) begin
            gp_oe <= wd[NGPIO-1:0];
         end else if (wa == `SPF_OFF0_SEL) begin
            off0_sel <= wd[NDAC-1:0];
         end else if (wa == `SPF_OFF1_SEL) begin
            off1_sel <= wd[NDAC-1:0];
         end else if (wa == `SPF_LIM_HI) begin
            lim_hi <= wd[DW-1:0];
         end else if (wa == `SPF_LIM_LO) begin
            lim_lo <= wd[DW-1:0];
         end else if (wa == `SPF_CONV && !busy) begin
            chan <= wd[2:0];
         end else if (wa == `SPF_DAC_PEND) begin
            pend[wd[11:10]] <= wd[DW-1:0];
         end else if (wa == `SPF_IRQ_MASK) begin
            mask <= wd[3:0];
         end
      end
   end

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   wire out_of_range = (adc_data > lim_hi) || (adc_data < lim_lo);

   always @(posedge mclk) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         busy <= 1'b0;
         cnt <= 11'h000;
         adc_sample <= 1'b0;
         analog_mux_sel <= 3'h0;
         result <= {DW{1'b0}};
         range_flag <= 1'b0;
         ev_done <= 1'b0;
         ev_range <= 1'b0;
         temp_sensor_en <= 1'b0;
      end else begin
         adc_sample <= 1'b0;
         ev_done <= 1'b0;
         ev_range <= 1'b0;
         temp_sensor_en <= ctrl[`SPF_C_TEMP];
         case (state)
            ST_IDLE: begin
               if (start) begin
                  state <= ST_CONV;
                  busy <= 1'b1;
                  analog_mux_sel <= wd[2:0];
                  adc_sample <= 1'b1;
                  // whole cycles, rounded down to stay inside the limit
                  if (ctrl[`SPF_C_TEMP]) begin
                     cnt <= TEMP_CYC - 11'h001;
                  end else begin
                     cnt <= CONV_CYC - 11'h001;
                  end
               end
            end
            ST_CONV: begin
               if (cnt == 11'h000) begin
                  state <= ST_IDLE;
                  busy <= 1'b0;
                  result <= adc_data;
                  range_flag <= out_of_range;
                  ev_done <= 1'b1;
                  ev_range <= out_of_range;
               end else begin
                  cnt <= cnt - 11'h001;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // shared pins
   // ----------------------------------------
   // polarity bit set means alert is active high
   wire alert_lvl = ctrl[`SPF_C_POL] ? range_flag : ~range_flag;

   always @(posedge mclk) begin
      if (!reset_n) begin
         gpio_out <= {NGPIO{1'b0}};
         gpio_oe <= {NGPIO{1'b0}};
      end else begin
         gpio_out <= gp_out;
         gpio_oe <= gp_oe;
         if (ctrl[`SPF_C_ALR0]) begin
            gpio_out[0] <= alert_lvl;
            gpio_oe[0] <= 1'b1;
         end
         if (ctrl[`SPF_C_ALR1]) begin
            gpio_out[1] <= alert_lvl;
            gpio_oe[1] <= 1'b1;
         end
         if (ctrl[`SPF_C_OFF0]) begin
            gpio_oe[2] <= 1'b0;
         end
         if (ctrl[`SPF_C_LOAD]) begin
            gpio_oe[3] <= 1'b0;
         end
         if (ctrl[`SPF_C_OFF1]) begin
            gpio_oe[4] <= 1'b0;
         end
         if (ctrl[`SPF_C_BUSY]) begin
            gpio_out[6] <= busy;
            gpio_oe[6] <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // dac load and disable
   // ----------------------------------------
   reg load_d;
   wire dac_load_strobe = s_gpio[3];
   wire dac_off_input_0 = s_gpio[2] & ctrl[`SPF_C_OFF0];
   wire dac_off_input_1 = s_gpio[4] & ctrl[`SPF_C_OFF1];
   wire load_go = dac_load_strobe & ~load_d & ctrl[`SPF_C_LOAD];

   always @(posedge mclk) begin
      if (!reset_n) begin
         load_d <= 1'b0;
         ev_load <= 1'b0;
         dac_out_en <= {NDAC{1'b0}};
         dac_codes <= {(NDAC * DW){1'b0}};
      end else begin
         load_d <= dac_load_strobe;
         ev_load <= load_go;
         dac_out_en <= ~(({NDAC{dac_off_input_0}} & off0_sel) |
                         ({NDAC{dac_off_input_1}} & off1_sel));
         if (load_go) begin
            for (j = 0; j < NDAC; j = j + 1) begin
               dac_codes[j*DW +: DW] <= pend[j];
            end
         end
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   // a new event beats a clear in the same cycle
   wire [3:0] events = {ev_frame, ev_load, ev_range, ev_done};
   wire [3:0] clr = (wr_en && wa == `SPF_IRQ_STAT) ? wd[3:0] : 4'h0;
   wire [3:0] next_stat = (stat & ~clr) | events;

   always @(posedge mclk) begin
      if (!reset_n) begin
         stat <= 4'h0;
         irq <= 1'b0;
      end else begin
         stat <= next_stat;
         irq <= |(next_stat & mask);
      end
   end

endmodule // spf_top

// ---- spf_regs.vh ----
// register offsets, field positions, reset values and timing counts
`ifndef SPF_REGS_VH
`define SPF_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SPF_CTRL 8'h00
`define SPF_GPIO_OUT 8'h04
`define SPF_GPIO_OE 8'h08
`define SPF_GPIO_IN 8'h0C
`define SPF_OFF0_SEL 8'h10
`define SPF_OFF1_SEL 8'h14
`define SPF_LIM_HI 8'h18
`define SPF_LIM_LO 8'h1C
`define SPF_CONV 8'h20
`define SPF_RESULT 8'h24
`define SPF_DAC_PEND 8'h28
`define SPF_IRQ_STAT 8'h2C
`define SPF_IRQ_MASK 8'h30

// ----------------------------------------
// control fields
// ----------------------------------------
`define SPF_C_BUSY 0
`define SPF_C_LOAD 1
`define SPF_C_OFF0 2
`define SPF_C_OFF1 3
`define SPF_C_ALR0 4
`define SPF_C_ALR1 5
`define SPF_C_POL 6
`define SPF_C_TEMP 7

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define SPF_I_DONE 0
`define SPF_I_RANGE 1
`define SPF_I_LOAD 2
`define SPF_I_FRAME 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define SPF_CTRL_RST 8'h00
`define SPF_LIM_HI_RST 10'h3FF
`define SPF_LIM_LO_RST 10'h000

// ----------------------------------------
// timing
// ----------------------------------------
`define SPF_CLK_MHZ 250
`define SPF_CONV_NS 950
`define SPF_CONV_TEMP_NS 5850
`define SPF_CONV_CYC (`SPF_CONV_NS * `SPF_CLK_MHZ / 1000)
`define SPF_CONV_TEMP_CYC (`SPF_CONV_TEMP_NS * `SPF_CLK_MHZ / 1000)

`endif

// ---- spf_sync.v ----
// two flip-flop synchroniser for pin inputs
module spf_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

   reg [W-1:0] meta;

   always @(posedge mclk) begin
      if (!reset_n) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // spf_sync

// ---- spf_host.sv ----
// serial host model: drives chip select, serial clock and data in
module spf_host (
   // serial pins
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // no pull on the line, so a released output reads as z
   wire line = dout_oe ? dout : 1'bz;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   // clock stands high outside frames; data moves just after rising
   task automatic frame(input logic [7:0] cmd, input logic [31:0] wd,
                        output logic [31:0] rd);
      logic [39:0] sh;
      sh = {cmd, wd};
      rd = 32'h0;
      cs_n = 1'b0;
      #16;
      for (int i = 0; i < 40; i++) begin
         din = sh[39 - i];
         #16 sclk = 1'b0;
         if (i >= 8) begin
            rd = {rd[30:0], line};
         end
         #16 sclk = 1'b1;
      end
      #16 cs_n = 1'b1;
      din = ~din;
   endtask
endmodule // spf_host

// ---- spf_top_chk.sv ----
// checker on the top ports: serial output, busy timing, dac pins
module spf_top_chk #(
   parameter NGPIO = 12,
   parameter NDAC = 4,
   parameter DW = 10
) (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // apb
   input wire psel,
   input wire penable,
   input wire pready,
   // serial pins
   input wire cs_n,
   input wire sclk,
   input wire dout,
   input wire dout_oe,
   // pins and analog side
   input wire [NGPIO-1:0] gpio_in,
   input wire [NGPIO-1:0] gpio_out,
   input wire [NGPIO-1:0] gpio_oe,
   input wire adc_sample,
   input wire temp_sensor_en,
   input wire [NDAC*DW-1:0] dac_codes,
   input wire [NDAC-1:0] dac_out_en
);
   localparam int T_CONV = 237;
   localparam int T_TEMP = 1462;
   logic busy_pin;
   logic [10:0] busy_cnt;
   assign busy_pin = gpio_out[6] && gpio_oe[6];
   // cycles the busy pin has stood high so far
   always_ff @(posedge mclk) begin
      if (!reset_n || !busy_pin) begin
         busy_cnt <= 11'h000;
      end else begin
         busy_cnt <= busy_cnt + 11'h001;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   chk_apb_ready: assert property (pready == (psel && penable))
      else $error("pready does not follow psel and penable");
   chk_oe_idle: assert property (cs_n [*6] |-> !dout_oe)
      else $error("dout driven with chip select high");
   chk_oe_frame: assert property ($rose(dout_oe) |-> !cs_n && !$past(cs_n, 4))
      else $error("dout driven outside a frame");
   chk_dout_edge: assert property (dout_oe && $changed(dout) |-> $past(sclk, 3))
      else $error("dout changed away from a rising serial clock");
   chk_busy_start: assert property (adc_sample && gpio_oe[6] |-> ##[0:3] gpio_out[6])
      else $error("busy pin did not rise at conversion start");
   chk_busy_len: assert property ($fell(busy_pin) |->
      busy_cnt == (temp_sensor_en ? T_TEMP : T_CONV))
      else $error("busy pin high time wrong");
   chk_load_cause: assert property ($changed(dac_codes) |-> $past(gpio_in[3], 2))
      else $error("dac codes changed without load strobe");
   chk_off_cause: assert property (|($past(dac_out_en) & ~dac_out_en) |->
      $past(gpio_in[2], 2) || $past(gpio_in[4], 2))
      else $error("dac output turned off without a disable input");
endmodule // spf_top_chk

// ---- spf_top_tb.sv ----
// testbench: apb and serial access, pin functions, conversions
`include "spf_regs.vh"
module spf_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0, reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, err, cs_n, sclk, din, dout, dout_oe;
   logic adc_sample, temp_sensor_en, irq;
   logic [11:0] gpio_in = 12'h000, gpio_out, gpio_oe;
   logic [2:0] analog_mux_sel;
   logic [9:0] adc_data = 10'h000;
   logic [39:0] dac_codes;
   logic [3:0] dac_out_en;
   int n_errors = 0, check_count = 0, cycles = 0;
   logic [11:0] busy_run = 12'h000;
   initial forever #2 mclk = ~mclk;
   spf_top u_dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .cs_n, .sclk, .din, .dout,
      .dout_oe, .gpio_in, .gpio_out, .gpio_oe, .analog_mux_sel,
      .adc_sample, .temp_sensor_en, .adc_data, .dac_codes, .dac_out_en,
      .irq);
   spf_host u_host (.cs_n, .sclk, .din, .dout, .dout_oe);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // serial clock phase kept off the mclk edges
   task spi(input logic [7:0] cmd, input logic [31:0] d);
      @(posedge mclk);
      #1 u_host.frame(cmd, d, rdv);
      cyc(8);
   endtask
   task conv(input logic [2:0] ch, input int len);
      apb(1'b1, `SPF_CONV, {29'h0, ch});
      cyc(3);
      chk("busy", gpio_out[6], 1'b1);
      chk("mux", analog_mux_sel, ch);
      // a second start while busy must be ignored
      apb(1'b1, `SPF_CONV, {29'h0, ~ch});
      chk("mux_hold", analog_mux_sel, ch);
      for (int k = 0; k < 2000 && gpio_out[6] !== 1'b0; k++) begin
         @(posedge mclk);
      end
      cyc(3);
      chk("busy_len", busy_run, len);
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      cyc(4);
      reset_n <= 1'b1;
      apb(1'b0, `SPF_LIM_HI, 32'h0);
      chk("lim_hi_rst", rdv, 32'h3FF);
      chk("mapped_err", err, 1'b0);
      apb(1'b0, `SPF_CTRL, 32'h0);
      chk("ctrl_rst", rdv, 32'h0);
      apb(1'b1, 8'h34, 32'hF);
      chk("unmapped_err", err, 1'b1);
      apb(1'b0, 8'h34, 32'h0);
      chk("unmapped_rd", rdv, 32'h0);
      apb(1'b1, `SPF_GPIO_OE, 32'hFFF);
      apb(1'b1, `SPF_GPIO_OUT, 32'h5AF);
      gpio_in <= 12'hA50;
      cyc(4);
      chk("gpio_out", gpio_out, 12'h5AF);
      chk("gpio_oe", gpio_oe, 12'hFFF);
      apb(1'b0, `SPF_GPIO_IN, 32'h0);
      chk("gpio_in", rdv, 32'hA50);
      apb(1'b1, `SPF_GPIO_OE, 32'h0);
      gpio_in <= 12'h000;
      $display("test registers done");
      spi(8'h06, 32'h155);
      apb(1'b0, `SPF_LIM_HI, 32'h0);
      chk("spi_write", rdv, 32'h155);
      spi(8'h86, 32'h0);
      chk("spi_read", rdv, 32'h155);
      chk("dout_release", dout_oe, 1'b0);
      $display("test serial done");
      apb(1'b1, `SPF_LIM_HI, 32'h200);
      apb(1'b1, `SPF_LIM_LO, 32'h10);
      apb(1'b1, `SPF_CTRL, 32'h71);
      adc_data <= 10'h300;
      conv(3'h5, `SPF_CONV_CYC);
      chk("alert_hi", gpio_out[1:0], 2'h3);
      chk("alert_oe", gpio_oe[1:0], 2'h3);
      apb(1'b0, `SPF_RESULT, 32'h0);
      chk("result", rdv, 32'h10300);
      apb(1'b0, `SPF_IRQ_STAT, 32'h0);
      chk("irq_stat", rdv, 32'hB);
      chk("irq_masked", irq, 1'b0);
      apb(1'b1, `SPF_IRQ_MASK, 32'h1);
      cyc(2);
      chk("irq_set", irq, 1'b1);
      apb(1'b1, `SPF_IRQ_STAT, 32'hF);
      cyc(2);
      chk("irq_clear", irq, 1'b0);
      apb(1'b1, `SPF_CTRL, 32'h31);
      adc_data <= 10'h005;
      conv(3'h7, `SPF_CONV_CYC);
      chk("alert_lo", gpio_out[1:0], 2'h0);
      apb(1'b1, `SPF_CTRL, 32'hB1);
      adc_data <= 10'h100;
      conv(3'h2, `SPF_CONV_TEMP_CYC);
      chk("alert_off", gpio_out[1:0], 2'h3);
      chk("temp_en", temp_sensor_en, 1'b1);
      $display("test conversions done");
      apb(1'b1, `SPF_DAC_PEND, 32'hAAB);
      gpio_in[3] <= 1'b1;
      cyc(8);
      chk("no_load", dac_codes, 40'h0);
      gpio_in[3] <= 1'b0;
      apb(1'b1, `SPF_CTRL, 32'h2);
      gpio_in[3] <= 1'b1;
      cyc(8);
      chk("load", dac_codes, 40'h2AB00000);
      apb(1'b0, `SPF_IRQ_STAT, 32'h0);
      chk("irq_load", rdv, 32'h7);
      gpio_in[3] <= 1'b0;
      apb(1'b1, `SPF_OFF0_SEL, 32'h5);
      apb(1'b1, `SPF_OFF1_SEL, 32'h8);
      apb(1'b1, `SPF_CTRL, 32'hC);
      gpio_in[2] <= 1'b1;
      cyc(8);
      chk("off0", dac_out_en, 4'hA);
      gpio_in[2] <= 1'b0;
      gpio_in[4] <= 1'b1;
      cyc(8);
      chk("off1", dac_out_en, 4'h7);
      $display("test dac pins done");
      close_out();
   end
   // busy pin high time, restarted by each sample pulse
   always @(posedge mclk) begin
      if (adc_sample === 1'b1) begin
         busy_run <= 12'h000;
      end else if (gpio_out[6] === 1'b1) begin
         busy_run <= busy_run + 12'h001;
      end
   end
   // a hang counts as a mismatch
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         close_out();
      end
   end
endmodule // spf_top_tb
bind spf_top spf_top_chk #(.NGPIO(NGPIO), .NDAC(NDAC), .DW(DW)) u_chk (
   .mclk, .reset_n, .psel, .penable, .pready, .cs_n, .sclk, .dout,
   .dout_oe, .gpio_in, .gpio_out, .gpio_oe, .adc_sample, .temp_sensor_en,
   .dac_codes, .dac_out_en);
